// file: dca_discrete_command_arbiter.sv
// Operation
// - closed contact reads TRUE, open reads FALSE
// - remote-select picks remote reference over raise/lower
// - command-source setting picks hardware or host link
// - override coil forces hardware, discrete or all
// - reset clears only alarms already normal
// - reset pulse bounded, re-arms after input drops
// - reset ORs contact, both ports, software switch
// - manifold raise ramps up to its cap
// - exhaust mode redirects raise to exhaust reference
// - manifold lower ramps down to its cap
// - exhaust mode redirects lower to exhaust reference
// - raise ramps speed up to speed cap
// - lower ramps speed down to speed cap
// - raise ignored while remote-select TRUE
// - lower ignored while remote-select TRUE
// - host raise/lower share same limits and rates
// - rated and permitted ramps to full speed
// - rated off or unpermitted ramps to low speed
// - raise, lower, remote contacts cancel rated ramp
// - run-permit FALSE forces fuel demand zero
// - signal one fails below 2.0 mA, above 21 mA
// - signal one failure latched until reset in range
module dca_discrete_command_arbiter #(
    parameter int DEBOUNCE_CYCLES = dca_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // contact inputs, high while closed
    input wire logic [7:0] discIn,
    // analog and process inputs
    input wire logic [15:0] hwRemoteRef,
    input wire logic [15:0] sig1Microamp,
    input wire logic exhActive,
    input wire logic [15:0] govFuel,
    // reset commands from the two serial ports
    input wire logic port2AlarmReset,
    input wire logic port3AlarmReset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData,
    // results
    output logic [7:0] discState,
    output logic alarmResetPulse,
    output logic sig1Fault,
    output logic [15:0] speedRef,
    output logic [15:0] mapRef,
    output logic [15:0] exhRef,
    output logic [15:0] fuelDemand
);

    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [5:0] ctrl;
    logic [15:0] hostRef;
    logic [15:0] cfg [dca_pkg::CFG_COUNT];
    logic swResetReq;
    logic resetArmed;
    logic ratedRamp;
    logic idleRamp;
    logic [7:0] dbPrev;
    logic discHw;
    logic anaHw;
    logic remote;
    logic raiseCmd;
    logic lowerCmd;
    logic [15:0] remoteRef;
    logic resetSrc;
    logic sig1Out;
    logic exhMode;
    logic cancelRated;
    logic [15:0] next_speedRef;

    ////////////////////////////////////////////////////////////////////////
    // step cur toward tgt by at most step, never past it
    function automatic logic [15:0] stepTo(input logic [15:0] cur, input logic [15:0] tgt,
                                           input logic [15:0] step);
        logic [16:0] sum;
        sum = {1'b0, cur} + {1'b0, step};
        if (cur < tgt) begin
            stepTo = (sum > {1'b0, tgt}) ? tgt : sum[15:0];
        end else if (cur - tgt < step) begin
            stepTo = tgt;
        end else begin
            stepTo = cur - step;
        end
    endfunction

    // only move upward; a reference already above the cap is left alone
    function automatic logic [15:0] raiseTo(input logic [15:0] cur, input logic [15:0] cap,
                                            input logic [15:0] step);
        raiseTo = (cur < cap) ? stepTo(cur, cap, step) : cur;
    endfunction

    function automatic logic [15:0] lowerTo(input logic [15:0] cur, input logic [15:0] cap,
                                            input logic [15:0] step);
        lowerTo = (cur > cap) ? stepTo(cur, cap, step) : cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronise and debounce each contact
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= discIn;
            sync2 <= sync1;
        end
    end

    for (genvar i = 0; i < dca_pkg::DI_COUNT; i++) begin : g_deb
        logic [CW-1:0] cnt;
        // a new level must hold for the whole window; chatter restarts it
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                cnt <= '0;
                discState[i] <= 1'b0;
            end else if (sync2[i] == discState[i]) begin
                cnt <= '0;
            end else if (cnt == CW'(DEBOUNCE_CYCLES - 1)) begin
                cnt <= '0;
                discState[i] <= sync2[i];
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dbPrev <= 8'h00;
        end else begin
            dbPrev <= discState;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl <= dca_pkg::CTRL_RESET;
            hostRef <= dca_pkg::REF_RESET;
            swResetReq <= 1'b0;
            for (int k = 0; k < dca_pkg::CFG_COUNT; k++) begin
                cfg[k] <= dca_pkg::CFG_RESET;
            end
        end else begin
            swResetReq <= 1'b0;
            if (wrStb) begin
                if (addr == dca_pkg::ADDR_CTRL) begin
                    ctrl <= wrData[dca_pkg::CTRL_WIDTH-1:0];
                    swResetReq <= wrData[dca_pkg::CTRL_SW_RESET];
                end else if (addr == dca_pkg::ADDR_HOST_REF) begin
                    hostRef <= wrData[15:0];
                end else if (addr >= dca_pkg::ADDR_CFG_FIRST && addr <= dca_pkg::ADDR_CFG_LAST
                             && addr[1:0] == 2'b00) begin
                    cfg[4'((addr - dca_pkg::ADDR_CFG_FIRST) >> 2)] <= wrData[15:0];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData <= 32'h0000_0000;
        end else if (rdStb) begin
            if (addr == dca_pkg::ADDR_CTRL) begin
                rdData <= {26'h0, ctrl};
            end else if (addr == dca_pkg::ADDR_HOST_REF) begin
                rdData <= {16'h0, hostRef};
            end else if (addr >= dca_pkg::ADDR_CFG_FIRST && addr <= dca_pkg::ADDR_CFG_LAST
                         && addr[1:0] == 2'b00) begin
                rdData <= {16'h0, cfg[4'((addr - dca_pkg::ADDR_CFG_FIRST) >> 2)]};
            end else if (addr == dca_pkg::ADDR_STATUS) begin
                rdData <= {21'h0, idleRamp, ratedRamp, sig1Fault, discState};
            end else if (addr == dca_pkg::ADDR_SPEED_REF) begin
                rdData <= {16'h0, speedRef};
            end else begin
                rdData <= 32'h0000_0000;
            end
        end else begin
            rdData <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command source selection
    always_comb begin
        discHw = !ctrl[dca_pkg::CTRL_USE_HOST] || ctrl[dca_pkg::CTRL_OVR_DISC]
                 || ctrl[dca_pkg::CTRL_OVR_ALL];
        anaHw = !ctrl[dca_pkg::CTRL_USE_HOST] || ctrl[dca_pkg::CTRL_OVR_ALL];
        remote = discState[dca_pkg::DI_REMOTE];
        // host coils go through the same ramp path as the contacts
        raiseCmd = !remote && (discHw ? discState[dca_pkg::DI_RAISE]
                                      : ctrl[dca_pkg::CTRL_HOST_RAISE]);
        lowerCmd = !remote && (discHw ? discState[dca_pkg::DI_LOWER]
                                      : ctrl[dca_pkg::CTRL_HOST_LOWER]);
        remoteRef = anaHw ? hwRemoteRef : hostRef;
        cancelRated = (discState[dca_pkg::DI_REMOTE] && !dbPrev[dca_pkg::DI_REMOTE])
                      || (discState[dca_pkg::DI_RAISE] && !dbPrev[dca_pkg::DI_RAISE])
                      || (discState[dca_pkg::DI_LOWER] && !dbPrev[dca_pkg::DI_LOWER]);
        exhMode = ctrl[dca_pkg::CTRL_EXH_SEL] && exhActive;
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm reset one-shot
    assign resetSrc = discState[dca_pkg::DI_ALMRST] || port2AlarmReset || port3AlarmReset
                      || swResetReq;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarmResetPulse <= 1'b0;
            resetArmed <= 1'b1;
        end else begin
            alarmResetPulse <= resetSrc && resetArmed;
            resetArmed <= !resetSrc;
        end
    end

    a_reset_single: assert property (@(posedge mclk) disable iff (!rst_n)
        alarmResetPulse |=> !alarmResetPulse)
        else $error("alarm reset pulse longer than one cycle");

    a_reset_rearm: assert property (@(posedge mclk) disable iff (!rst_n)
        alarmResetPulse ##1 resetSrc [*2] |=> !alarmResetPulse)
        else $error("alarm reset repeated while source held");

    ////////////////////////////////////////////////////////////////////////
    // signal input one fault latch
    assign sig1Out = sig1Microamp < dca_pkg::SIG1_LOW_UA
                     || sig1Microamp > dca_pkg::SIG1_HIGH_UA;

    // a new failure wins over a reset in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sig1Fault <= 1'b0;
        end else if (sig1Out) begin
            sig1Fault <= 1'b1;
        end else if (alarmResetPulse) begin
            sig1Fault <= 1'b0;
        end
    end

    a_fault_set: assert property (@(posedge mclk) disable iff (!rst_n)
        sig1Out |=> sig1Fault)
        else $error("signal one failure not flagged");

    a_fault_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        sig1Fault && (sig1Out || !alarmResetPulse) |=> sig1Fault)
        else $error("signal one failure cleared early");

    ////////////////////////////////////////////////////////////////////////
    // rated and idle ramp modes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ratedRamp <= 1'b0;
            idleRamp <= 1'b0;
        end else if (cancelRated) begin
            ratedRamp <= 1'b0;
            idleRamp <= 1'b0;
        end else if (!discState[dca_pkg::DI_RATED] || !discState[dca_pkg::DI_RUN]) begin
            ratedRamp <= 1'b0;
            // only a falling rated or permit starts the idle ramp
            if (dbPrev[dca_pkg::DI_RATED] && dbPrev[dca_pkg::DI_RUN]) begin
                idleRamp <= 1'b1;
            end
        end else if (!dbPrev[dca_pkg::DI_RATED] || !dbPrev[dca_pkg::DI_RUN]) begin
            ratedRamp <= 1'b1;
            idleRamp <= 1'b0;
        end
    end

    a_rated_cancel: assert property (@(posedge mclk) disable iff (!rst_n)
        cancelRated |=> !ratedRamp)
        else $error("rated ramp survived raise, lower or remote");

    ////////////////////////////////////////////////////////////////////////
    // speed reference
    always_comb begin
        next_speedRef = speedRef;
        if (remote) begin
            next_speedRef = remoteRef;
            if (remoteRef > cfg[dca_pkg::CFG_SPD_UP_CAP]) begin
                next_speedRef = cfg[dca_pkg::CFG_SPD_UP_CAP];
            end else if (remoteRef < cfg[dca_pkg::CFG_SPD_DN_CAP]) begin
                next_speedRef = cfg[dca_pkg::CFG_SPD_DN_CAP];
            end
        end else if (raiseCmd) begin
            next_speedRef = raiseTo(speedRef, cfg[dca_pkg::CFG_SPD_UP_CAP],
                                    cfg[dca_pkg::CFG_SPD_RATE]);
        end else if (lowerCmd) begin
            next_speedRef = lowerTo(speedRef, cfg[dca_pkg::CFG_SPD_DN_CAP],
                                    cfg[dca_pkg::CFG_SPD_RATE]);
        end else if (ratedRamp) begin
            next_speedRef = stepTo(speedRef, cfg[dca_pkg::CFG_FULL_SPD],
                                   cfg[dca_pkg::CFG_ACCEL_STEP]);
        end else if (idleRamp) begin
            next_speedRef = stepTo(speedRef, cfg[dca_pkg::CFG_LOW_SPD],
                                   cfg[dca_pkg::CFG_DECEL_STEP]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            speedRef <= dca_pkg::REF_RESET;
        end else begin
            speedRef <= next_speedRef;
        end
    end

    a_raise_moves: assert property (@(posedge mclk) disable iff (!rst_n)
        raiseCmd && cfg[dca_pkg::CFG_SPD_RATE] != 16'h0000
        && speedRef < cfg[dca_pkg::CFG_SPD_UP_CAP] |=> speedRef > $past(speedRef))
        else $error("speed reference did not rise");

    a_lower_moves: assert property (@(posedge mclk) disable iff (!rst_n)
        lowerCmd && !raiseCmd && cfg[dca_pkg::CFG_SPD_RATE] != 16'h0000
        && speedRef > cfg[dca_pkg::CFG_SPD_DN_CAP] |=> speedRef < $past(speedRef))
        else $error("speed reference did not fall");

    a_remote_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        remote |-> !raiseCmd && !lowerCmd)
        else $error("raise or lower active under remote select");

    ////////////////////////////////////////////////////////////////////////
    // manifold pressure and exhaust temperature references
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mapRef <= dca_pkg::REF_RESET;
            exhRef <= dca_pkg::REF_RESET;
        end else if (exhMode) begin
            if (discState[dca_pkg::DI_MAPUP]) begin
                exhRef <= raiseTo(exhRef, cfg[dca_pkg::CFG_EXH_UP_CAP],
                                  cfg[dca_pkg::CFG_EXH_RATE]);
            end else if (discState[dca_pkg::DI_MAPDN]) begin
                exhRef <= lowerTo(exhRef, cfg[dca_pkg::CFG_EXH_DN_CAP],
                                  cfg[dca_pkg::CFG_EXH_RATE]);
            end
        end else if (discState[dca_pkg::DI_MAPUP]) begin
            mapRef <= raiseTo(mapRef, cfg[dca_pkg::CFG_MAP_UP_CAP],
                              cfg[dca_pkg::CFG_MAP_RATE]);
        end else if (discState[dca_pkg::DI_MAPDN]) begin
            mapRef <= lowerTo(mapRef, cfg[dca_pkg::CFG_MAP_DN_CAP],
                              cfg[dca_pkg::CFG_MAP_RATE]);
        end
    end

    a_map_up: assert property (@(posedge mclk) disable iff (!rst_n)
        !exhMode && discState[dca_pkg::DI_MAPUP] |=> mapRef >= $past(mapRef)
        && (mapRef <= $past(cfg[dca_pkg::CFG_MAP_UP_CAP]) || mapRef == $past(mapRef)))
        else $error("manifold reference raise wrong");

    a_exh_redirect: assert property (@(posedge mclk) disable iff (!rst_n)
        exhMode |=> mapRef == $past(mapRef))
        else $error("manifold reference moved in exhaust mode");

    ////////////////////////////////////////////////////////////////////////
    // fuel demand gate; the permit drop zeroes fuel on the next edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fuelDemand <= 16'h0000;
        end else if (!discState[dca_pkg::DI_RUN]) begin
            fuelDemand <= 16'h0000;
        end else begin
            fuelDemand <= govFuel;
        end
    end

    a_fuel_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !discState[dca_pkg::DI_RUN] |=> fuelDemand == 16'h0000)
        else $error("fuel demand not zero without run permit");

endmodule

// file: dca_pkg.sv
package dca_pkg;

    // clock and debounce timing
    localparam int CLK_HZ = 50_000_000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

    // discrete input positions
    localparam int DI_REMOTE = 0;
    localparam int DI_ALMRST = 1;
    localparam int DI_MAPUP = 2;
    localparam int DI_MAPDN = 3;
    localparam int DI_RAISE = 4;
    localparam int DI_LOWER = 5;
    localparam int DI_RATED = 6;
    localparam int DI_RUN = 7;
    localparam int DI_COUNT = 8;

    // signal input one limits, microamps
    localparam logic [15:0] SIG1_LOW_UA = 16'h07D0;
    localparam logic [15:0] SIG1_HIGH_UA = 16'h5208;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HOST_REF = 8'h04;
    localparam logic [7:0] ADDR_CFG_FIRST = 8'h08;
    localparam logic [7:0] ADDR_CFG_LAST = 8'h38;
    localparam logic [7:0] ADDR_STATUS = 8'h3C;
    localparam logic [7:0] ADDR_SPEED_REF = 8'h40;

    // configuration word indices, address = ADDR_CFG_FIRST + 4 * index
    localparam int CFG_SPD_UP_CAP = 0;
    localparam int CFG_SPD_DN_CAP = 1;
    localparam int CFG_SPD_RATE = 2;
    localparam int CFG_FULL_SPD = 3;
    localparam int CFG_LOW_SPD = 4;
    localparam int CFG_ACCEL_STEP = 5;
    localparam int CFG_DECEL_STEP = 6;
    localparam int CFG_MAP_UP_CAP = 7;
    localparam int CFG_MAP_DN_CAP = 8;
    localparam int CFG_MAP_RATE = 9;
    localparam int CFG_EXH_UP_CAP = 10;
    localparam int CFG_EXH_DN_CAP = 11;
    localparam int CFG_EXH_RATE = 12;
    localparam int CFG_COUNT = 13;

    // control register fields
    localparam int CTRL_USE_HOST = 0;
    localparam int CTRL_OVR_DISC = 1;
    localparam int CTRL_OVR_ALL = 2;
    localparam int CTRL_EXH_SEL = 3;
    localparam int CTRL_HOST_RAISE = 4;
    localparam int CTRL_HOST_LOWER = 5;
    localparam int CTRL_SW_RESET = 6;
    localparam int CTRL_WIDTH = 6;

    // reset values
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] REF_RESET = 16'h0000;

endpackage

// file: dca_contact_model.sv
module dca_contact_model (
    // clock
    input wire logic mclk,
    // wanted contact positions, 1 = closed
    input wire logic [7:0] closed,
    // terminal levels seen by the controller
    output logic [7:0] discIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] target = 8'h00;
    logic [7:0] moving = 8'h00;
    int bounce = 0;
    initial discIn = 8'h00;
    ////////////////////////////////////////////////////////////////
    // real contacts bounce, so a change chatters before it settles
    always @(posedge mclk) begin
        if (closed !== target) begin
            moving <= closed ^ target;
            target <= closed;
            bounce <= 3;
        end else if (bounce > 0) begin
            discIn <= discIn ^ moving;
            bounce <= bounce - 1;
        end else begin
            discIn <= target;
        end
    end
endmodule

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] closed = 8'h00;
    logic [7:0] discIn;
    logic [15:0] hwRemoteRef = 16'h0000;
    logic [15:0] sig1Microamp = 16'h1F40;
    logic exhActive = 1'b0;
    logic [15:0] govFuel = 16'h0000;
    logic port2AlarmReset = 1'b0;
    logic port3AlarmReset = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h00000000;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [31:0] rdData;
    logic [7:0] discState;
    logic alarmResetPulse;
    logic sig1Fault;
    logic [15:0] speedRef, mapRef, exhRef, fuelDemand;
    int errTotal = 0;
    int nTests = 0;
    int seed = 1;
    int v, n;
    int cfgv[13] = '{1000, 200, 7, 800, 500, 25, 30, 300, 40, 50, 600, 100, 60};

    always #10 mclk = ~mclk;

    dca_contact_model i_dca_contact_model (.mclk(mclk), .closed(closed), .discIn(discIn));

    // short debounce keeps the run brief
    dca_discrete_command_arbiter #(.DEBOUNCE_CYCLES(4)) i_dca_discrete_command_arbiter (
        .mclk(mclk), .rst_n(rst_n), .discIn(discIn), .hwRemoteRef(hwRemoteRef),
        .sig1Microamp(sig1Microamp), .exhActive(exhActive), .govFuel(govFuel),
        .port2AlarmReset(port2AlarmReset), .port3AlarmReset(port3AlarmReset),
        .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .discState(discState), .alarmResetPulse(alarmResetPulse), .sig1Fault(sig1Fault),
        .speedRef(speedRef), .mapRef(mapRef), .exhRef(exhRef), .fuelDemand(fuelDemand));

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic hang;
        errTotal++;
        $display("ERROR at %0t: wait limit reached", $time);
        end_of_test();
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask

    task automatic waitSt(input int b, input logic val);
        int k;
        k = 0;
        while (discState[b] !== val && k < 40) begin
            tick(1);
            k++;
        end
        if (k == 40) hang();
    endtask

    function automatic logic [15:0] outv(input int sel);
        return (sel == 0) ? speedRef : (sel == 1) ? mapRef : exhRef;
    endfunction

    // reference model: one rate step per clock, clamped at the cap
    task automatic ramp(input int sel, input bit up, input int rate, input int cap);
        int m, k;
        m = outv(sel);
        k = 0;
        while (outv(sel) == m && k < 40) begin
            tick(1);
            k++;
        end
        if (k == 40) hang();
        while (m != cap) begin
            m = up ? ((m + rate > cap) ? cap : m + rate) : ((m - rate < cap) ? cap : m - rate);
            chk(outv(sel), m);
            tick(1);
        end
        tick(3);
        chk(outv(sel), cap);
    endtask

    task automatic cnt(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            if (alarmResetPulse === 1'b1) n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        rst_n <= 1'b1;
        rd(8'h3C, 32'h00000000);
        rd(8'h40, 32'h00000000);
        rd(8'h44, 32'h00000000);
        for (int i = 0; i < 13; i++) begin
            v = $random(seed);
            wr(8'h08 + 8'(4 * i), v);
            rd(8'h08 + 8'(4 * i), {16'h0000, v[15:0]});
        end
        for (int i = 0; i < 13; i++) wr(8'h08 + 8'(4 * i), cfgv[i]);
        closed[4] <= 1'b1;
        ramp(0, 1, 7, 1000);
        closed[4] <= 1'b0;
        closed[5] <= 1'b1;
        ramp(0, 0, 7, 200);
        closed[5] <= 1'b0;
        tick(20);
        closed[4] <= 1'b1;
        tick(18);
        closed[4] <= 1'b0;
        tick(20);
        v = speedRef;
        tick(6);
        chk(speedRef, v);
        hwRemoteRef <= 16'h012C + 16'($random(seed) & 32'h1FF);
        closed[0] <= 1'b1;
        waitSt(0, 1'b1);
        closed[4] <= 1'b1;
        tick(20);
        chk(speedRef, hwRemoteRef);
        closed[4] <= 1'b0;
        closed[5] <= 1'b1;
        tick(20);
        chk(speedRef, hwRemoteRef);
        closed[5] <= 1'b0;
        hwRemoteRef <= 16'h1388;
        tick(4);
        chk(speedRef, 32'h000003E8);
        // host reference, then partial and full hardware override
        wr(8'h04, 32'h00000258);
        wr(8'h00, 32'h00000001);
        tick(2);
        chk(speedRef, 32'h00000258);
        wr(8'h00, 32'h00000003);
        tick(2);
        chk(speedRef, 32'h00000258);
        wr(8'h00, 32'h00000005);
        tick(2);
        chk(speedRef, 32'h000003E8);
        wr(8'h00, 32'h00000000);
        closed[0] <= 1'b0;
        waitSt(0, 1'b0);
        wr(8'h00, 32'h00000021);
        ramp(0, 0, 7, 200);
        wr(8'h00, 32'h00000013);
        tick(10);
        chk(speedRef, 32'h000000C8);
        wr(8'h00, 32'h00000000);
        closed[2] <= 1'b1;
        ramp(1, 1, 50, 300);
        closed[2] <= 1'b0;
        closed[3] <= 1'b1;
        ramp(1, 0, 50, 40);
        closed[3] <= 1'b0;
        wr(8'h00, 32'h00000008);
        exhActive <= 1'b1;
        tick(12);
        closed[2] <= 1'b1;
        ramp(2, 1, 60, 600);
        chk(mapRef, 32'h00000028);
        closed[2] <= 1'b0;
        closed[3] <= 1'b1;
        ramp(2, 0, 60, 100);
        closed[3] <= 1'b0;
        exhActive <= 1'b0;
        wr(8'h00, 32'h00000000);
        sig1Microamp <= 16'h07CF;
        tick(3);
        chk(sig1Fault, 1'b1);
        port2AlarmReset <= 1'b1;
        cnt(10);
        port2AlarmReset <= 1'b0;
        chk(n, 1);
        chk(sig1Fault, 1'b1);
        sig1Microamp <= 16'h07D0;
        tick(3);
        chk(sig1Fault, 1'b1);
        closed[1] <= 1'b1;
        cnt(30);
        chk(n, 1);
        chk(sig1Fault, 1'b0);
        closed[1] <= 1'b0;
        // once the contact drops, the one-shot re-arms for the serial ports too
        waitSt(1, 1'b0);
        sig1Microamp <= 16'h5209;
        tick(3);
        chk(sig1Fault, 1'b1);
        sig1Microamp <= 16'h5208;
        port3AlarmReset <= 1'b1;
        cnt(5);
        port3AlarmReset <= 1'b0;
        chk(n, 1);
        chk(sig1Fault, 1'b0);
        sig1Microamp <= 16'h07CF;
        tick(3);
        sig1Microamp <= 16'h1F40;
        wr(8'h00, 32'h00000040);
        tick(3);
        chk(sig1Fault, 1'b0);
        govFuel <= 16'($random(seed));
        closed[7] <= 1'b1;
        waitSt(7, 1'b1);
        tick(2);
        chk(fuelDemand, govFuel);
        closed[6] <= 1'b1;
        ramp(0, 1, 25, 800);
        rd(8'h3C, 32'h000002C0);
        closed[4] <= 1'b1;
        waitSt(4, 1'b1);
        closed[4] <= 1'b0;
        waitSt(4, 1'b0);
        rd(8'h3C, 32'h000000C0);
        v = speedRef;
        tick(6);
        chk(speedRef, v);
        closed[6] <= 1'b0;
        ramp(0, 0, 30, 500);
        closed[7] <= 1'b0;
        waitSt(7, 1'b0);
        tick(1);
        chk(fuelDemand, 32'h00000000);
        end_of_test();
    end
endmodule
